// ---- verilog/ast_pkg.sv ----
// Purpose: Constants and types for the serial string transmitter.
// Assumes: One 10 MHz system clock; no software registers.
// Notes: Rate codes select 300 to 19,200 bits per second.
// Overview of operation
// - Each character goes out as start bit, eight data bits, stop bit.
// - Every bit cell lasts one second divided by the chosen bit rate.
// - Stop bit may be held longer; receiver accepts any stop length.
// - Parallel-load shift register loads whole frame, shifts one bit per tick.
// - Each frame starts with the line low for one bit period.
// - Data bits are shifted right onto the line, least significant first.
// - Each data bit is held one bit period timed by the rate count.
// - Bit counter loads eight, counts down, data phase ends at zero.
// - Stop bit drives high, then next character or idle forever.
// - After each reset release the whole string is sent exactly once.
// - Bit rates 300 to 19,200 selectable; period derived from clock.
// - Direct-connection option inverts every transmitted level.
// - With switched driver power, wait 1.5 ms before the first start bit.
package ast_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned PWR_WAIT_NS = 1500000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  // Least time, so rounded up.
  localparam int unsigned PWR_WAIT_CYC =
    (PWR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BITS_PER_CHAR = 8;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam int unsigned MSG_LEN = 9;
  localparam logic [7:0] MSG_TEXT [0:MSG_LEN-1] = '{
    8'h54, 8'h65, 8'h73, 8'h74, 8'h20, 8'h6d, 8'h73, 8'h67, 8'h0a};
  localparam logic [2:0] RATE_300 = 3'h0;
  localparam logic [2:0] RATE_600 = 3'h1;
  localparam logic [2:0] RATE_1200 = 3'h2;
  localparam logic [2:0] RATE_2400 = 3'h3;
  localparam logic [2:0] RATE_4800 = 3'h4;
  localparam logic [2:0] RATE_9600 = 3'h5;
  localparam logic [2:0] RATE_19200 = 3'h6;
  localparam int unsigned SLOWEST_BPS = 300;
  localparam int unsigned FASTEST_BPS = 19200;
  typedef enum logic [6:0] {
    S_PWR   = 7'h01,
    S_FETCH = 7'h02,
    S_LOAD  = 7'h04,
    S_START = 7'h08,
    S_DATA  = 7'h10,
    S_STOP  = 7'h20,
    S_DONE  = 7'h40
  } ast_state_t;
endpackage

// ---- verilog/ast_rom_if.sv ----
// Purpose: Character fetch path between sequencer and message store.
// Assumes: Read data valid one clock after the address.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface ast_rom_if #(parameter int AW = 4);
  logic [AW-1:0] addr;
  logic [7:0] data;
  modport seq (output addr, input data);
  modport mem (input addr, output data);
endinterface
`default_nettype wire

// ---- verilog/ast_msg_rom.sv ----
// Purpose: Fixed message store with registered read data.
// Assumes: Address is held in range by the sequencer.
// Notes: Out-of-range addresses read as zero.
`timescale 1ns/1ps
`default_nettype none
module ast_msg_rom #(parameter int AW = 4) (
  input wire logic sys_clk,
  input wire logic rst,
  ast_rom_if.mem rom
);
  import ast_pkg::*;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom.data <= 8'h00;
    end else if (int'(rom.addr) < MSG_LEN) begin
      rom.data <= MSG_TEXT[rom.addr];
    end else begin
      rom.data <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ast_tx.sv ----
// Purpose: Sends the stored text string once after reset as serial frames.
// Assumes: Inputs synchronous to sys_clk; sys_clk at ast_pkg::CLK_HZ.
// Notes: Optional switched driver power with a settle delay.
`timescale 1ns/1ps
`default_nettype none
module ast_tx #(
  parameter int unsigned CLK_HZ = ast_pkg::CLK_HZ,
  parameter int unsigned PWR_WAIT = ast_pkg::PWR_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] rate_sel,
  input wire logic direct_conn,
  input wire logic pwr_switched,
  output logic drv_pwr_en,
  output logic serial_tx_pin,
  output logic done
);
  import ast_pkg::*;

  localparam int AW = 4;

  if (CLK_HZ / SLOWEST_BPS > 65536 ||
      CLK_HZ / FASTEST_BPS < 2) begin : g_bad_clk
    $error("CLK_HZ out of range for the bit period counter.");
  end
  if (PWR_WAIT < 1 || PWR_WAIT > 16777215) begin : g_bad_wait
    $error("PWR_WAIT out of range.");
  end

  // ****************************************************************
  // Bit period selection.
  // ****************************************************************
  function automatic logic [15:0] period_m1(input logic [2:0] sel);
    int unsigned bps;
    bps = FASTEST_BPS;
    unique case (sel)
      RATE_300: bps = 300;
      RATE_600: bps = 600;
      RATE_1200: bps = 1200;
      RATE_2400: bps = 2400;
      RATE_4800: bps = 4800;
      RATE_9600: bps = 9600;
      default: bps = FASTEST_BPS;
    endcase
    return 16'(CLK_HZ / bps - 1);
  endfunction

  ast_state_t state_r;
  logic [15:0] per_r;
  logic [15:0] tmr_r;
  logic [23:0] pwr_cnt_r;
  logic [9:0] shreg_r;
  logic [3:0] bit_cnt_r;
  logic [AW-1:0] idx_r;
  logic inv_r;
  logic tick;
  logic in_frame;

  ast_rom_if #(.AW(AW)) rom ();

  ast_msg_rom #(.AW(AW)) u_rom (
    .sys_clk(sys_clk),
    .rst(rst),
    .rom(rom)
  );

  assign rom.addr = idx_r;
  assign tick = (tmr_r == 16'h0000);
  assign in_frame = (state_r == S_START) || (state_r == S_DATA) ||
                    (state_r == S_STOP);

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_PWR;
    end else begin
      unique case (state_r)
        // The wait counter is loaded only once power is up, so a zero
        // before that must not end the wait.
        S_PWR: if (!pwr_switched ||
            (drv_pwr_en && pwr_cnt_r == 24'h000000)) begin
          state_r <= S_FETCH;
        end
        S_FETCH: state_r <= S_LOAD;
        S_LOAD: state_r <= S_START;
        S_START: if (tick) begin
          state_r <= S_DATA;
        end
        S_DATA: if (tick && bit_cnt_r == 4'h1) begin
          state_r <= S_STOP;
        end
        S_STOP: if (tick) begin
          // More characters fetch again; fetch cycles stretch the stop.
          if (int'(idx_r) == MSG_LEN - 1) begin
            state_r <= S_DONE;
          end else begin
            state_r <= S_FETCH;
          end
        end
        S_DONE: state_r <= S_DONE;
        default: state_r <= S_DONE;
      endcase
    end
  end

  // Driver power comes up at reset release and drops after the string only when pwr_switched is set.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_cnt_r <= 24'h000000;
      drv_pwr_en <= 1'b0;
    end else if (state_r == S_PWR) begin
      drv_pwr_en <= 1'b1;
      if (!drv_pwr_en) begin
        pwr_cnt_r <= 24'(PWR_WAIT - 1);
      end else if (pwr_cnt_r != 24'h000000) begin
        pwr_cnt_r <= pwr_cnt_r - 24'h000001;
      end
    end else begin
      drv_pwr_en <= !(state_r == S_DONE && pwr_switched);
    end
  end

  // Bit period timer; the rate is captured at each frame load.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_r <= 16'h0000;
      tmr_r <= 16'h0000;
    end else if (state_r == S_LOAD) begin
      per_r <= period_m1(rate_sel);
      tmr_r <= period_m1(rate_sel);
    end else if (in_frame) begin
      tmr_r <= tick ? per_r : tmr_r - 16'h0001;
    end
  end

  // Frame shift register and counters.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shreg_r <= 10'h3ff;
      bit_cnt_r <= 4'h0;
      idx_r <= '0;
    end else if (state_r == S_LOAD) begin
      shreg_r <= {1'b1, rom.data, 1'b0};
      bit_cnt_r <= DATA_BITS;
    end else if (in_frame && tick) begin
      shreg_r <= {1'b1, shreg_r[9:1]};
      if (state_r == S_DATA) begin
        bit_cnt_r <= bit_cnt_r - 4'h1;
      end
      if (state_r == S_STOP && int'(idx_r) != MSG_LEN - 1) begin
        idx_r <= idx_r + 1'b1;
      end
    end
  end

  // Line driver; idle is the stop level, optionally inverted.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inv_r <= 1'b0;
      serial_tx_pin <= 1'b1;
      done <= 1'b0;
    end else begin
      inv_r <= direct_conn;
      serial_tx_pin <= (in_frame ? shreg_r[0] : 1'b1) ^ direct_conn;
      done <= (state_r == S_DONE);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  start_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_r == S_START) |=> serial_tx_pin == inv_r)
    else $error("Start bit not low.");
  idle_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_DONE && $past(state_r == S_DONE)) |=>
      serial_tx_pin == !inv_r)
    else $error("Idle line not at stop level.");
  bit_cell_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in_frame && tick && state_r != S_STOP) |=> tmr_r == per_r)
    else $error("Bit timer not reloaded.");
  data_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_DATA && $past(state_r) == S_START) |->
      bit_cnt_r == 4'h8 ##0 (state_r == S_DATA)[*1])
    else $error("Data phase did not start with eight.");
  data_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_DATA && !(tick && bit_cnt_r == 4'h1)) |=>
      state_r == S_DATA)
    else $error("Data phase left early.");
  lsb_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_DATA && tick) |=>
      shreg_r == {1'b1, $past(shreg_r[9:1])})
    else $error("Data not shifted right.");
  load_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_LOAD) |=>
      shreg_r == {1'b1, $past(rom.data), 1'b0} && bit_cnt_r == 4'h8)
    else $error("Frame not loaded in parallel.");
  stop_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_STOP && $past(state_r == S_STOP)) |->
      serial_tx_pin == !inv_r)
    else $error("Stop bit not high.");
  once_only_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_DONE) |=> state_r == S_DONE && !in_frame)
    else $error("Transmission after string end.");
  rate_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (in_frame && $past(in_frame)) |-> $stable(per_r))
    else $error("Bit rate changed inside a frame.");
  pwr_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == S_FETCH && $past(state_r == S_PWR) && pwr_switched) |->
      $past(pwr_cnt_r) == 24'h000000 && $past(drv_pwr_en) && drv_pwr_en)
    else $error("Start before driver power settled.");
endmodule
`default_nettype wire

// ---- verif/ast_rx_model.sv ----
// Purpose: Terminal model that frames bytes off the serial line.
// Assumes: Period is given in sys_clk cycles and is at least 2.
// Notes: The framing error flag is sticky for the whole run.
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic line,
  input wire logic inv,
  input wire logic [15:0] period,
  output logic [7:0] rx_byte,
  output logic rx_stb,
  output logic rx_err,
  output logic [19:0] last_edge
);
  logic lvl;
  logic prev_r;
  logic busy_r;
  logic [19:0] cnt_r;
  logic [19:0] bitn;
  assign lvl = line ^ inv;
  assign bitn = cnt_r / 20'(period);
  initial rx_err = 1'b0;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      busy_r <= 1'b0;
      rx_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      prev_r <= lvl;
      if (!busy_r) begin
        // Idle of any length is accepted before a start edge.
        if (prev_r && !lvl) begin
          busy_r <= 1'b1;
          cnt_r <= 20'h1;
          last_edge <= 20'h0;
        end
      end else begin
        cnt_r <= cnt_r + 20'h1;
        if (lvl != prev_r) last_edge <= cnt_r;
        if (cnt_r % 20'(period) == (20'(period) >> 1)) begin
          if (bitn == 20'h0 && lvl) rx_err <= 1'b1;
          if (bitn >= 20'h1 && bitn <= 20'h8) begin
            rx_byte <= {lvl, rx_byte[7:1]};
          end
          if (bitn == 20'h9) begin
            rx_err <= rx_err | !lvl;
            rx_stb <= 1'b1;
            busy_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ast_tx_bench.sv ----
// Purpose: Self-checking bench for the serial string transmitter.
// Assumes: Clock lowered to 96 kHz so cells stay short.
// Notes: Expected periods come from the bit rate table.
`timescale 1ns/1ps
`default_nettype none
module ast_tx_bench;
  import ast_pkg::*;
  localparam int unsigned TB_HZ = 96000;
  localparam int unsigned TB_WAIT = 20;
  logic sys_clk, rst, direct_conn, pwr_switched;
  logic [2:0] rate_sel;
  logic drv_pwr_en, serial_tx_pin, done, rx_stb, rx_err;
  logic [15:0] period;
  logic [7:0] rx_byte;
  logic [19:0] last_edge;
  logic [7:0] got[$];
  logic [19:0] edges[$];
  int n_errors;
  int checks;
  ast_tx #(.CLK_HZ(TB_HZ), .PWR_WAIT(TB_WAIT)) ast_tx_i (.sys_clk(sys_clk),
    .rst(rst), .rate_sel(rate_sel), .direct_conn(direct_conn),
    .pwr_switched(pwr_switched), .drv_pwr_en(drv_pwr_en),
    .serial_tx_pin(serial_tx_pin), .done(done));
  ast_rx_model ast_rx_model_i (.sys_clk(sys_clk), .rst(rst),
    .line(serial_tx_pin), .inv(direct_conn), .period(period),
    .rx_byte(rx_byte), .rx_stb(rx_stb), .rx_err(rx_err),
    .last_edge(last_edge));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rx_stb === 1'b1) begin
      got.push_back(rx_byte);
      edges.push_back(last_edge);
    end
  end
  function automatic int per(input logic [2:0] code);
    case (code)
      3'h0: return TB_HZ / 300;
      3'h1: return TB_HZ / 600;
      3'h2: return TB_HZ / 1200;
      3'h3: return TB_HZ / 2400;
      3'h4: return TB_HZ / 4800;
      3'h5: return TB_HZ / 9600;
      default: return TB_HZ / 19200;
    endcase
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] code, input logic inv,
    input logic pwr);
    @(posedge sys_clk);
    #5;
    rst = 1'b1;
    rate_sel = code;
    direct_conn = inv;
    pwr_switched = pwr;
    period = 16'(per(code));
    @(posedge sys_clk);
    #5;
    chk(serial_tx_pin === 1'b1 && drv_pwr_en === 1'b0 && done === 1'b0,
      "reset outputs");
    rst = 1'b0;
    got.delete();
    edges.delete();
  endtask
  task automatic wait_bytes(input int n, input int lim);
    int k;
    k = 0;
    while (got.size() < n && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
  endtask
  task automatic chk_string();
    for (int i = 0; i < MSG_LEN; i++) begin
      chk(got[i] === MSG_TEXT[i], "string byte");
    end
  endtask
  task automatic t_string();
    do_reset(3'h6, 1'b0, 1'b0);
    wait_bytes(3, 2000);
    do_reset(3'h6, 1'b0, 1'b0);
    wait_bytes(MSG_LEN, 5000);
    chk_string();
    repeat (200) @(posedge sys_clk);
    #5;
    chk(got.size() == MSG_LEN && done === 1'b1, "sent once");
    chk(serial_tx_pin === 1'b1 && drv_pwr_en === 1'b1, "idle");
  endtask
  task automatic t_rates();
    // The first character ends in a zero, so its last edge is the stop.
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c), 1'b0, 1'b0);
      wait_bytes(1, 12 * per(3'(c)) + 20);
      chk(got[0] === MSG_TEXT[0], "rate byte");
      chk(edges[0] === 20'(9 * per(3'(c))), "bit period");
    end
  endtask
  task automatic t_direct_pwr();
    int k;
    do_reset(3'h5, 1'b1, 1'b1);
    @(posedge sys_clk);
    #1;
    k = 0;
    while (serial_tx_pin === 1'b0 && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(k >= TB_WAIT && drv_pwr_en === 1'b1, "power settle");
    wait_bytes(MSG_LEN, 2000);
    chk_string();
    repeat (50) @(posedge sys_clk);
    #5;
    chk(drv_pwr_en === 1'b0 && serial_tx_pin === 1'b0, "off idle");
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    rate_sel = 3'h6;
    direct_conn = 1'b0;
    pwr_switched = 1'b0;
    period = 16'(per(3'h6));
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    t_string();
    t_rates();
    t_direct_pwr();
    chk(rx_err === 1'b0, "framing");
    close_out();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
